//--- icf_ctrl.sv
// Control-flag logic of a byte-oriented two-wire bus interface
// Function
// - Source select picks timer overflow or generator
// - Acknowledge own or general call address
// - Acknowledge data in master or slave receive
// - Acknowledge disabled leaves data line high
// - Any defined state entry sets event flag
// - Interrupt while flag and both enables set
// - Master halt request sends halt, self clears
// - Slave halt request makes internal halt only
// - Slave halt returns unaddressed, clears request
// - Begin request enters master, begins if free
// - Busy bus: wait halt, then half period
// - Begin request while master gives repeated begin
// - Begin request accepted in any state
// - Enable bit switches sequencer, flag setting, ack and pins on, off
// - Timer source bit rate is overflow half
// - Both requests: halt then begin, slave internal
// - Generator holds clock high, low periods
// - General call recognised only when enabled
`default_nettype none
module icf_ctrl (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire icf_pkg::icf_av_req_type av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  input wire icf_pkg::icf_evt_type evt,
  input wire logic t1_ovf,
  input wire logic global_irq_enable,
  input wire logic bus_irq_enable,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq,
  output logic master_mode,
  output logic internal_halt
);
  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    logic en;          // Interface enable
    logic begin_req;   // Begin condition request
    logic halt_req;    // Halt condition request
    logic si;          // Transfer event flag
    logic ack_en;      // Acknowledge enable
    logic src_sel;     // SCL source select
    logic [7:0] own;   // Own address and gc bit
    logic [7:0] sclh;  // High period
    logic [7:0] scll;  // Low period
    icf_pkg::icf_state_type st;  // Sequencer state
    logic [7:0] cnt;   // Phase counter
    logic scl_rel;     // SCL released
    logic sda_rel;     // SDA released
    logic [2:0] scl_s; // SCL synchroniser
    logic [2:0] sda_s; // SDA synchroniser
    logic scl_f;       // Filtered SCL
    logic sda_f;       // Filtered SDA
    logic busy;        // Bus busy
    logic waited;      // A busy bus was seen
    logic begun;       // Request already served
    logic irq;         // Interrupt output
    logic ihalt;       // Internal halt pulse
    logic [31:0] rdata;  // Read data
    logic wreq;        // Waitrequest
    logic mstr;        // Master mode output
  } icf_st_type;

  icf_st_type st_r;    // Registered state
  icf_st_type st_nxt;  // Next state

  // Reload value for an N cycle phase
  function automatic logic [7:0] icf_load(input logic [7:0] n);
    icf_load = (n == 8'h00) ? 8'h00 : n - 8'h01;
  endfunction : icf_load

  // Phase end: timer overflow or counter expiry
  function automatic logic icf_tick(input logic sel, input logic ovf,
                                    input logic [7:0] c);
    icf_tick = sel ? ovf : (c == 8'h00);
  endfunction : icf_tick

  logic go;           // Request accepted this edge
  logic wr_go;        // Write takes effect
  logic tick;         // Phase end
  logic sda_rise;     // Filtered SDA rise, SCL high
  logic sda_fall;     // Filtered SDA fall, SCL high
  logic addr_hit;     // Address byte addresses us
  logic ack_now;      // Pull SDA low for acknowledge

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    go = (av_req.read | av_req.write) & ~st_r.wreq;
    wr_go = go & av_req.write;
    tick = icf_tick(st_r.src_sel, t1_ovf, st_r.cnt);
    addr_hit = 1'b0;
    ack_now = 1'b0;
    // Bus slave handshake, one wait cycle per access
    st_nxt.wreq = ~((av_req.read | av_req.write) & st_r.wreq);
    if ((av_req.read | av_req.write) & st_r.wreq) begin
      case (av_req.address)
        icf_pkg::CTRL_ADDR: begin
          st_nxt.rdata = '0;
          st_nxt.rdata[icf_pkg::B_SRC] = st_r.src_sel;
          st_nxt.rdata[icf_pkg::B_ACK] = st_r.ack_en;
          st_nxt.rdata[icf_pkg::B_SI] = st_r.si;
          st_nxt.rdata[icf_pkg::B_HALT] = st_r.halt_req;
          st_nxt.rdata[icf_pkg::B_BEGIN] = st_r.begin_req;
          st_nxt.rdata[icf_pkg::B_EN] = st_r.en;
        end
        icf_pkg::OWNADR_ADDR: st_nxt.rdata = {24'h000000, st_r.own};
        icf_pkg::SCLH_ADDR: st_nxt.rdata = {24'h000000, st_r.sclh};
        icf_pkg::SCLL_ADDR: st_nxt.rdata = {24'h000000, st_r.scll};
        // Status: busy, master, sequencer state
        icf_pkg::STAT_ADDR: st_nxt.rdata = {27'h0000000, st_r.busy,
                                           st_r.st != icf_pkg::ST_IDLE,
                                           st_r.st};
        default: st_nxt.rdata = icf_pkg::UNMAPPED_RD;
      endcase
    end
    // Register writes
    if (wr_go) begin
      case (av_req.address)
        icf_pkg::CTRL_ADDR: begin
          st_nxt.en = av_req.writedata[icf_pkg::B_EN];
          st_nxt.begin_req = av_req.writedata[icf_pkg::B_BEGIN];
          st_nxt.halt_req = av_req.writedata[icf_pkg::B_HALT];
          st_nxt.ack_en = av_req.writedata[icf_pkg::B_ACK];
          st_nxt.src_sel = av_req.writedata[icf_pkg::B_SRC];
          // Zero clears the flag, one is ignored
          if (!av_req.writedata[icf_pkg::B_SI])
            st_nxt.si = 1'b0;
          // A fresh begin request may be served again
          if (av_req.writedata[icf_pkg::B_BEGIN])
            st_nxt.begun = 1'b0;
        end
        icf_pkg::OWNADR_ADDR: st_nxt.own = av_req.writedata[7:0];
        icf_pkg::SCLH_ADDR: st_nxt.sclh = av_req.writedata[7:0];
        icf_pkg::SCLL_ADDR: st_nxt.scll = av_req.writedata[7:0];
        default: st_nxt.en = st_nxt.en;
      endcase
    end
    // Pin synchronisers, change counts when stages two and three agree
    st_nxt.scl_s = {st_r.scl_s[1:0], scl_in};
    st_nxt.sda_s = {st_r.sda_s[1:0], sda_in};
    if (st_r.scl_s[1] == st_r.scl_s[2])
      st_nxt.scl_f = st_r.scl_s[2];
    if (st_r.sda_s[1] == st_r.sda_s[2])
      st_nxt.sda_f = st_r.sda_s[2];
    sda_rise = st_r.scl_f & st_nxt.scl_f & ~st_r.sda_f & st_nxt.sda_f;
    sda_fall = st_r.scl_f & st_nxt.scl_f & st_r.sda_f & ~st_nxt.sda_f;
    // Bus busy between begin and halt on the wire
    if (sda_fall)
      st_nxt.busy = 1'b1;
    else if (sda_rise)
      st_nxt.busy = 1'b0;
    // Event flag, set wins over a software clear
    if (st_r.en & evt.state_enter)
      st_nxt.si = 1'b1;
    // Interrupt request follows the flag and both enables
    st_nxt.irq = st_nxt.si & global_irq_enable & bus_irq_enable;
    // Address recognition, general call only with gc bit set
    addr_hit = (evt.rx_byte[7:1] == st_r.own[7:1]) |
               ((evt.rx_byte == icf_pkg::GC_ADDR) &
                st_r.own[icf_pkg::B_GC]);
    // Acknowledge slot drive
    ack_now = st_r.en & evt.ack_slot & st_r.ack_en &
              (evt.addr_phase ? addr_hit : evt.rx_mode);
    st_nxt.ihalt = 1'b0;
    // Phase counter runs down and rests at zero
    st_nxt.cnt = icf_load(st_r.cnt);
    // Sequencer
    case (st_r.st)
      icf_pkg::ST_IDLE: begin
        st_nxt.scl_rel = 1'b1;
        st_nxt.sda_rel = ~ack_now;
        if (st_r.en & st_r.halt_req) begin
          // Slave halt: internal only, back to unaddressed
          st_nxt.halt_req = 1'b0;
          st_nxt.ihalt = 1'b1;
        end else if (st_r.en & st_r.begin_req & ~st_r.begun) begin
          st_nxt.st = icf_pkg::ST_WAIT;
          st_nxt.waited = 1'b0;
        end
      end
      icf_pkg::ST_WAIT: begin
        if (st_r.busy) begin
          st_nxt.waited = 1'b1;
        end else if (st_r.waited) begin
          st_nxt.st = icf_pkg::ST_HALF;
          st_nxt.cnt = icf_load(st_r.sclh);
        end else begin
          st_nxt.st = icf_pkg::ST_BEGIN;
          st_nxt.cnt = icf_load(st_r.sclh);
        end
      end
      icf_pkg::ST_HALF: begin
        if (tick) begin
          st_nxt.st = icf_pkg::ST_BEGIN;
          st_nxt.cnt = icf_load(st_r.sclh);
        end
      end
      icf_pkg::ST_BEGIN: begin
        // Data low while clock high
        st_nxt.scl_rel = 1'b1;
        st_nxt.sda_rel = 1'b0;
        if (tick) begin
          st_nxt.st = icf_pkg::ST_MSTR;
          st_nxt.begun = 1'b1;
          st_nxt.scl_rel = 1'b0;
          st_nxt.cnt = icf_load(st_r.scll);
        end
      end
      icf_pkg::ST_MSTR: begin
        st_nxt.sda_rel = ~ack_now;
        // Clock: overflow toggles (rate halves) or high/low counts
        if (tick) begin
          st_nxt.scl_rel = ~st_r.scl_rel;
          st_nxt.cnt = st_r.scl_rel ? icf_load(st_r.scll)
                                    : icf_load(st_r.sclh);
        end
        if (st_r.halt_req & tick & st_r.scl_rel) begin
          st_nxt.st = icf_pkg::ST_HLO;
          st_nxt.scl_rel = 1'b0;
          st_nxt.cnt = icf_load(st_r.scll);
        end else if (st_r.begin_req & ~st_r.begun & tick & st_r.scl_rel)
        begin
          st_nxt.st = icf_pkg::ST_RBEG;
          st_nxt.scl_rel = 1'b0;
          st_nxt.cnt = icf_load(st_r.scll);
        end
      end
      icf_pkg::ST_RBEG: begin
        // Data released, then clock released, then begin
        st_nxt.sda_rel = 1'b1;
        if (tick & ~st_r.scl_rel) begin
          st_nxt.scl_rel = 1'b1;
          st_nxt.cnt = icf_load(st_r.sclh);
        end else if (tick) begin
          st_nxt.st = icf_pkg::ST_BEGIN;
          st_nxt.cnt = icf_load(st_r.sclh);
        end
      end
      icf_pkg::ST_HLO: begin
        // Data low, clock low, then clock released
        st_nxt.sda_rel = 1'b0;
        if (tick & ~st_r.scl_rel) begin
          st_nxt.scl_rel = 1'b1;
          st_nxt.cnt = icf_load(st_r.sclh);
        end else if (tick) begin
          st_nxt.st = icf_pkg::ST_HHI;
          st_nxt.sda_rel = 1'b1;
        end
      end
      icf_pkg::ST_HHI: begin
        st_nxt.sda_rel = 1'b1;
        // Halt seen on the wire clears the request
        if (sda_rise) begin
          st_nxt.halt_req = 1'b0;
          st_nxt.begun = 1'b0;
          st_nxt.waited = 1'b0;
          st_nxt.st = st_r.begin_req ? icf_pkg::ST_WAIT
                                     : icf_pkg::ST_IDLE;
        end
      end
      default: st_nxt.st = icf_pkg::ST_IDLE;
    endcase
    // Disabled: function off, pins released
    if (!st_r.en) begin
      st_nxt.st = icf_pkg::ST_IDLE;
      st_nxt.scl_rel = 1'b1;
      st_nxt.sda_rel = 1'b1;
    end
    st_nxt.mstr = (st_nxt.st != icf_pkg::ST_IDLE);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.sclh <= icf_pkg::SCLH_RST;
      st_r.scll <= icf_pkg::SCLL_RST;
      st_r.st <= icf_pkg::ST_IDLE;
      st_r.scl_rel <= 1'b1;
      st_r.sda_rel <= 1'b1;
      st_r.scl_s <= 3'h7;
      st_r.sda_s <= 3'h7;
      st_r.scl_f <= 1'b1;
      st_r.sda_f <= 1'b1;
      st_r.wreq <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state record
  assign av_readdata = st_r.rdata;
  assign av_waitrequest = st_r.wreq;
  assign scl_out = st_r.scl_rel;
  assign scl_oe_n = st_r.scl_rel;
  assign sda_out = st_r.sda_rel;
  assign sda_oe_n = st_r.sda_rel;
  assign irq = st_r.irq;
  assign master_mode = st_r.mstr;
  assign internal_halt = st_r.ihalt;

  // ****************************************
  // Checks
  // ****************************************
  property p_si_set;
    @(posedge core_clk) disable iff (sys_rst)
    st_r.en & evt.state_enter |=> st_r.si;
  endproperty
  a_si_set: assert property (p_si_set) else $error("flag not set");
  property p_irq;
    @(posedge core_clk) disable iff (sys_rst)
    st_r.si & global_irq_enable & bus_irq_enable ##1
    (global_irq_enable & bus_irq_enable & st_r.si) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_w1_si;
    @(posedge core_clk) disable iff (sys_rst)
    !st_r.si & !evt.state_enter |=> !st_r.si;
  endproperty
  a_w1_si: assert property (p_w1_si) else $error("flag self set");
  property p_ack;
    @(posedge core_clk) disable iff (sys_rst)
    ack_now & (st_r.st == icf_pkg::ST_IDLE) |=> !sda_oe_n;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack drive");
  property p_nack;
    @(posedge core_clk) disable iff (sys_rst)
    evt.ack_slot & !st_r.ack_en & (st_r.st == icf_pkg::ST_IDLE)
    |=> sda_oe_n;
  endproperty
  a_nack: assert property (p_nack) else $error("ack while off");
  property p_slave_halt;
    @(posedge core_clk) disable iff (sys_rst)
    st_r.en & st_r.halt_req & (st_r.st == icf_pkg::ST_IDLE)
    |=> internal_halt & !st_r.halt_req & scl_oe_n;
  endproperty
  a_slave_halt: assert property (p_slave_halt)
    else $error("slave halt");
  property p_halt_clr;
    @(posedge core_clk) disable iff (sys_rst)
    (st_r.st == icf_pkg::ST_HHI) & sda_rise & st_r.en |=> !st_r.halt_req;
  endproperty
  a_halt_clr: assert property (p_halt_clr)
    else $error("halt not cleared");
  property p_off;
    @(posedge core_clk) disable iff (sys_rst)
    !st_r.en |=> !master_mode & scl_oe_n & sda_oe_n;
  endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_wait;
    @(posedge core_clk) disable iff (sys_rst)
    av_req.read & av_waitrequest |=> !av_waitrequest ##1 av_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  c_begin: cover property (@(posedge core_clk)
    st_r.st == icf_pkg::ST_BEGIN ##1 st_r.st == icf_pkg::ST_MSTR);
  c_rbeg: cover property (@(posedge core_clk)
    st_r.st == icf_pkg::ST_RBEG);
  c_halt: cover property (@(posedge core_clk)
    st_r.st == icf_pkg::ST_HHI ##1 st_r.st == icf_pkg::ST_IDLE);
endmodule : icf_ctrl
`default_nettype wire

//--- icf_pkg.sv
// Shared constants and carrier types of the control-flag block
`default_nettype none
package icf_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_ADDR = 8'hd8;    // Control flags
  localparam logic [7:0] OWNADR_ADDR = 8'hdc;  // Own slave address, gc bit
  localparam logic [7:0] SCLH_ADDR = 8'he0;    // SCL high period
  localparam logic [7:0] SCLL_ADDR = 8'he4;    // SCL low period
  localparam logic [7:0] STAT_ADDR = 8'he8;    // Block status, read only
  // ****************************************
  // Control register field positions
  // ****************************************
  localparam int B_SRC = 0;    // SCL source select
  localparam int B_ACK = 2;    // Acknowledge enable
  localparam int B_SI = 3;     // Transfer event flag
  localparam int B_HALT = 4;   // Halt condition request
  localparam int B_BEGIN = 5;  // Begin condition request
  localparam int B_EN = 6;     // Interface enable
  localparam int B_GC = 0;     // General call enable in own address
  // ****************************************
  // Reset values and constants
  // ****************************************
  localparam logic [7:0] SCLH_RST = 8'h04;  // Default high period
  localparam logic [7:0] SCLL_RST = 8'h04;  // Default low period
  localparam logic [7:0] GC_ADDR = 8'h00;   // General call address
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;  // Unmapped reads
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,   // Slave, not master
    ST_WAIT = 3'b001,   // Waiting for bus free
    ST_HALF = 3'b010,   // Half period delay after stop
    ST_BEGIN = 3'b011,  // Driving begin condition
    ST_MSTR = 3'b100,   // Master, clocking bytes
    ST_HLO = 3'b101,    // Halt, low phase
    ST_HHI = 3'b110,    // Halt, waiting for halt on bus
    ST_RBEG = 3'b111    // Repeated begin setup
  } icf_state_type;
  // Events from the byte engine
  typedef struct packed {
    logic state_enter;  // Pulse: a defined bus state was entered
    logic ack_slot;     // Level: acknowledge clock slot now
    logic addr_phase;   // Level: the byte just taken is an address
    logic rx_mode;      // Level: master rx or addressed slave rx
    logic [7:0] rx_byte;  // Byte just received
  } icf_evt_type;
  // Avalon-MM request
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } icf_av_req_type;
endpackage : icf_pkg
`default_nettype wire

//--- icf_bus_peer.sv
// Far bus party: pull-ups, start and stop maker, condition counter
`default_nettype none
module icf_bus_peer (
  input wire logic core_clk,
  input wire logic dut_scl_oe_n,
  input wire logic dut_sda_oe_n,
  output logic scl_line,
  output logic sda_line,
  output var int starts_seen,
  output var int stops_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Line state
  // ****************
  logic scl_low = 1'b0; // Peer pulls clock low
  logic sda_low = 1'b0; // Peer pulls data low
  logic scl_d = 1'b1; // Clock level one edge ago
  logic sda_d = 1'b1; // Data level one edge ago
  int n_start = 0; // Begin conditions seen
  int n_stop = 0; // Halt conditions seen
  // Wired-AND with pull-ups, so a released line reads high
  assign scl_line = dut_scl_oe_n & ~scl_low;
  assign sda_line = dut_sda_oe_n & ~sda_low;
  assign starts_seen = n_start;
  assign stops_seen = n_stop;
  // Data edge while clock stays high marks a condition
  always @(posedge core_clk) begin
    scl_d <= scl_line;
    sda_d <= sda_line;
    if (scl_d && scl_line && sda_d && !sda_line) n_start <= n_start + 1;
    if (scl_d && scl_line && !sda_d && sda_line) n_stop <= n_stop + 1;
  end
  // Takes the bus: begin condition, then clock held low
  task automatic make_start(input int gap);
    @(posedge core_clk);
    sda_low <= 1'b1;
    repeat (gap) @(posedge core_clk);
    scl_low <= 1'b1;
  endtask : make_start
  // Frees the bus: clock released, then data released
  task automatic make_stop(input int gap);
    repeat (gap) @(posedge core_clk);
    scl_low <= 1'b0;
    repeat (gap) @(posedge core_clk);
    sda_low <= 1'b0;
  endtask : make_stop
  // Holds the clock low or lets it go, as a master does around a slot
  task automatic hold_scl(input logic v);
    @(posedge core_clk);
    scl_low <= v;
  endtask : hold_scl
endmodule : icf_bus_peer
`default_nettype wire

//--- testbench.sv
// Self-checking bench of the control-flag block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals
  // ****************
  logic core_clk = 1'b0; // Core clock
  logic sys_rst = 1'b1; // Sync reset
  icf_pkg::icf_av_req_type av_req = '0; // Register request
  icf_pkg::icf_evt_type evt = '0; // Byte engine events
  logic t1_ovf = 1'b0; // Timer overflow pulse
  logic global_irq_enable = 1'b0; // Global enable
  logic bus_irq_enable = 1'b0; // Block enable
  logic [31:0] av_readdata, rd; // Read data
  logic av_waitrequest, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic irq, master_mode, internal_halt, scl_line, sda_line;
  int starts, stops, n, t, s0, halts = 0;
  int num_errors = 0; // Mismatches
  int num_checks = 0; // Comparisons
  logic [31:0] acks [6] = '{32'ha444a404, 32'ha4440005, 32'ha5440004,
    32'ha4443c02, 32'ha4403c03, 32'ha4443005}; // Ack cases
  icf_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .evt(evt),
    .t1_ovf(t1_ovf), .global_irq_enable(global_irq_enable),
    .bus_irq_enable(bus_irq_enable), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq(irq), .master_mode(master_mode),
    .internal_halt(internal_halt));
  icf_bus_peer peer (.core_clk(core_clk), .dut_scl_oe_n(scl_oe_n),
    .dut_sda_oe_n(sda_oe_n), .scl_line(scl_line), .sda_line(sda_line),
    .starts_seen(starts), .stops_seen(stops));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Counts slave-mode internal halt pulses
  always @(posedge core_clk) begin
    if (internal_halt === 1'b1) halts <= halts + 1;
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One bus access, held until waitrequest is seen low
  task automatic av_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d);
    @(posedge core_clk);
    av_req <= '{~w, w, a, d};
    do begin
      @(posedge core_clk);
    end while (av_waitrequest !== 1'b0);
    rd = av_readdata;
    av_req <= '0;
  endtask : av_xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    av_xfer(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    av_xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  // Bounded wait for a condition count on the wire
  task automatic upto(input logic stp, input int v);
    for (n = 0; n < 900 && (stp ? stops : starts) != v; n++)
      @(posedge core_clk);
  endtask : upto
  task automatic pulse();
    @(posedge core_clk);
    evt.state_enter <= 1'b1;
    @(posedge core_clk);
    evt.state_enter <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : pulse
  // Length in cycles of the next clock-drive level lv
  task automatic level_len(input logic lv, output int c);
    for (c = 0; c < 500 && scl_oe_n === lv; c++) @(posedge core_clk);
    for (c = 0; c < 500 && scl_oe_n !== lv; c++) @(posedge core_clk);
    for (c = 0; c < 500 && scl_oe_n === lv; c++) @(posedge core_clk);
  endtask : level_len
  // Overflow pulses every gap cycles, counting clock-drive toggles
  task automatic tog(input int cyc, input int gap, output int c);
    logic p;
    c = 0;
    p = scl_oe_n;
    for (int i = 0; i < cyc; i++) begin
      @(posedge core_clk);
      t1_ovf <= (gap != 0) && (i % gap == 0);
      if (scl_oe_n !== p) c++;
      p = scl_oe_n;
    end
  endtask : tog
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Watchdog, far beyond the expected run length
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdchk(icf_pkg::CTRL_ADDR, 32'h0);
    rdchk(icf_pkg::SCLH_ADDR, 32'h4);
    rdchk(icf_pkg::SCLL_ADDR, 32'h4);
    wr(8'hf0, 32'hff);
    rdchk(8'hf0, icf_pkg::UNMAPPED_RD);
    $display("test reset done");
    wr(icf_pkg::CTRL_ADDR, 32'h48);
    rdchk(icf_pkg::CTRL_ADDR, 32'h40);
    pulse();
    rdchk(icf_pkg::CTRL_ADDR, 32'h48);
    for (int i = 0; i < 4; i++) begin
      global_irq_enable <= i[0];
      bus_irq_enable <= i[1];
      repeat (3) @(posedge core_clk);
      chk(irq, 32'(i == 3));
    end
    rdchk(icf_pkg::CTRL_ADDR, 32'h48);
    wr(icf_pkg::CTRL_ADDR, 32'h40);
    rdchk(icf_pkg::CTRL_ADDR, 32'h40);
    repeat (3) @(posedge core_clk);
    chk(irq, 32'h0);
    wr(icf_pkg::CTRL_ADDR, 32'h0);
    pulse();
    rdchk(icf_pkg::CTRL_ADDR, 32'h0);
    chk(sda_oe_n & scl_oe_n & sda_out & scl_out, 32'h1);
    $display("test flag done");
    foreach (acks[i]) begin
      wr(icf_pkg::OWNADR_ADDR, acks[i][31:24]);
      wr(icf_pkg::CTRL_ADDR, acks[i][23:16]);
      // Peer holds the clock low so the slot makes no bus condition
      peer.hold_scl(1'b1);
      evt <= '{1'b0, 1'b1, acks[i][2], acks[i][1], acks[i][15:8]};
      repeat (8) @(posedge core_clk);
      chk(sda_oe_n, acks[i][0]);
      evt <= '0;
      repeat (2) @(posedge core_clk);
      peer.hold_scl(1'b0);
    end
    rdchk(icf_pkg::OWNADR_ADDR, 32'ha4);
    $display("test ack done");
    wr(icf_pkg::SCLH_ADDR, 32'h5);
    wr(icf_pkg::SCLL_ADDR, 32'h7);
    wr(icf_pkg::CTRL_ADDR, 32'h60);
    upto(1'b0, 1);
    chk(starts, 32'h1);
    chk(master_mode, 32'h1);
    level_len(1'b0, t);
    chk(t, 32'h7);
    level_len(1'b1, t);
    chk(t, 32'h5);
    wr(icf_pkg::CTRL_ADDR, 32'h60);
    upto(1'b0, 2);
    chk(starts, 32'h2);
    chk(stops, 32'h0);
    wr(icf_pkg::CTRL_ADDR, 32'h50);
    upto(1'b1, 1);
    chk(stops, 32'h1);
    repeat (8) @(posedge core_clk);
    rdchk(icf_pkg::CTRL_ADDR, 32'h40);
    chk(master_mode, 32'h0);
    $display("test master done");
    wr(icf_pkg::CTRL_ADDR, 32'h50);
    repeat (10) @(posedge core_clk);
    chk(halts, 32'h1);
    chk(stops, 32'h1);
    rdchk(icf_pkg::CTRL_ADDR, 32'h40);
    chk(master_mode, 32'h0);
    s0 = starts;
    peer.make_start(3);
    wr(icf_pkg::CTRL_ADDR, 32'h60);
    repeat (60) @(posedge core_clk);
    chk(starts, s0 + 1);
    chk(sda_oe_n, 32'h1);
    chk(master_mode, 32'h1);
    rdchk(icf_pkg::STAT_ADDR, 32'h19);
    peer.make_stop(3);
    upto(1'b0, s0 + 2);
    chk(starts, s0 + 2);
    chk(32'(n >= 12), 32'h1);
    $display("test busy done");
    s0 = starts;
    t = stops;
    wr(icf_pkg::CTRL_ADDR, 32'h70);
    upto(1'b1, t + 1);
    chk(starts, s0);
    upto(1'b0, s0 + 1);
    chk(starts, s0 + 1);
    wr(icf_pkg::CTRL_ADDR, 32'h50);
    upto(1'b1, t + 2);
    s0 = starts;
    wr(icf_pkg::CTRL_ADDR, 32'h61);
    tog(96, 12, t);
    chk(starts, s0 + 1);
    tog(60, 0, t);
    chk(t, 32'h0);
    tog(96, 12, t);
    chk(t, 32'h8);
    $display("test timer done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
